// File: logic/camd_decoder.sv
// Instruction fetch, addressing mode decode and operand address formation for an 8-bit CPU.
// Assumes memory answers a read one cycle after mem_rd and takes a write in the cycle of mem_wr.
//
// Behaviour
// - Inherent instructions are the opcode alone, form no address and touch only CPU registers.
// - Immediate instructions are two bytes, the second used directly as the operand with no address.
// - Direct instructions are two bytes; the second byte is the low address and the high byte is zero.
// - Extended instructions are three bytes giving the full address high byte first.
// - Indexed no-offset instructions are one byte and address zero page by the index register.
// - Indexed 8-bit offset instructions are two bytes and address index plus offset unsigned.
// - Indexed 16-bit offset instructions are three bytes and add the index to a high-first offset.
// - A taken relative branch adds the sign-extended offset to the next address, else falls through.
// - Bit test-and-branch is three bytes: direct address of the byte, then a signed offset.
// - The tested bit number and the wanted sense both come from the opcode.
// - The tested bit is copied to carry whether or not the branch is taken.
// - Bit test-and-branch reaches any bit in the lowest 256 addresses.
// - Read-modify-write reads the operand, alters it and writes it back to the same place.
// - The negative-or-zero test reads and sets flags but never writes back.
// - Register/memory instructions pair the accumulator or index with a memory operand.
// - All branches are relative and jumps take no immediate operand.
`timescale 1ns/1ns
module camd_decoder
  import camd_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Sequencing control.
  input wire logic run,
  input wire logic load_pc,
  input wire logic [15:0] load_addr,
  output logic busy,
  output logic instr_done,
  // CPU register values.
  input wire logic [7:0] acc,
  input wire logic [7:0] idx,
  input wire logic carry_in,
  input wire logic cond_true,
  // Memory side.
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // Decode results.
  output logic [15:0] pc,
  output logic [7:0] opcode,
  output camd_mode_t mode,
  output camd_class_t iclass,
  output logic [1:0] instr_len,
  output logic [15:0] operand_ea,
  output logic [7:0] operand_data,
  output logic operand_valid,
  output logic branch_taken,
  output logic subr_call,
  // Flag and register write-back.
  output logic carry_wr,
  output logic carry_val,
  output logic flag_wr,
  output logic flag_n,
  output logic flag_z,
  output logic reg_wr_acc,
  output logic reg_wr_idx,
  output logic [7:0] reg_wdata
);

  // Refuse address widths the 16-bit offset arithmetic cannot serve.
  if (ADDR_W != 16) begin : g_bad_width
    $error("camd_decoder supports only a 16-bit address space.");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_REQ, ST_CAP, ST_ADDR, ST_OPREQ, ST_OPCAP, ST_EXEC, ST_WR
  } camd_state_t;

  camd_state_t state_r, state_nxt;
  logic [7:0] byte_r [3];
  logic [1:0] cnt_r;
  logic [15:0] pc_r, pc_nxt;
  logic [7:0] operand_r, operand_nxt;
  logic [7:0] wdata_nxt;
  logic mem_rd_r, mem_wr_r;
  logic [15:0] mem_addr_r;
  logic [7:0] mem_wdata_r;
  logic [7:0] op_cur;
  camd_mode_t mode_cur;
  camd_class_t cls_cur;
  logic [1:0] len_cur;
  logic done, taken, is_store, store_idx, rmw_on_reg, no_writeback;
  logic tested_bit, want_high;
  logic [7:0] rmw_res, bit_res;
  logic instr_done_r, operand_valid_r, branch_taken_r, subr_call_r;
  logic carry_wr_r, carry_val_r, flag_wr_r, flag_n_r, flag_z_r;
  logic reg_wr_acc_r, reg_wr_idx_r;
  logic [7:0] reg_wdata_r;

  camd_ea_if ea_bus ();

  camd_ea_calc u_calc (
    .ea(ea_bus.calc)
  );

  // Alteration applied by the read-modify-write column rows.
  function automatic logic [7:0] camd_modify(input logic [3:0] lo, input logic [7:0] v, input logic c);
    case (lo)
      LO_NEG: camd_modify = 8'h00 - v;
      LO_COM: camd_modify = ~v;
      LO_LSR: camd_modify = {1'b0, v[7:1]};
      LO_ROR: camd_modify = {c, v[7:1]};
      LO_ASR: camd_modify = {v[7], v[7:1]};
      LO_LSL: camd_modify = {v[6:0], 1'b0};
      LO_ROL: camd_modify = {v[6:0], c};
      LO_DEC: camd_modify = v - 8'h01;
      LO_INC: camd_modify = v + 8'h01;
      LO_CLR: camd_modify = 8'h00;
      default: camd_modify = v;
    endcase
  endfunction : camd_modify

  // The opcode arrives on the bus in its capture cycle and is held afterwards.
  assign op_cur = (state_r == ST_CAP && cnt_r == 2'h0) ? mem_rdata : byte_r[0];
  assign mode_cur = camd_mode_of(op_cur);
  assign cls_cur = camd_class_of(op_cur);
  assign len_cur = camd_len_of(mode_cur);

  // Operand bytes and index to the address calculator; pc already points past the instruction.
  assign ea_bus.mode = mode_cur;
  assign ea_bus.idx = idx;
  assign ea_bus.b1 = byte_r[1];
  assign ea_bus.b2 = byte_r[2];
  assign ea_bus.pc_next = pc_r;

  // Side decodes used by the sequencer.
  assign store_idx = (byte_r[0][3:0] == LO_STORE_IDX);
  assign is_store = (byte_r[0][3:0] == LO_STORE_ACC) || store_idx;
  assign rmw_on_reg = (mode_cur == MODE_INH);
  assign no_writeback = (byte_r[0][3:0] == LO_TEST_NEGATIVE_ZERO);
  assign tested_bit = operand_r[byte_r[0][BIT_SEL_LSB +: 3]];
  assign want_high = ~byte_r[0][BIT_SENSE_POS];
  assign rmw_res = camd_modify(byte_r[0][3:0], operand_r, carry_in);
  always_comb begin
    bit_res = operand_r;
    bit_res[byte_r[0][BIT_SEL_LSB +: 3]] = want_high;
  end

  // Next state, next pc, operand source and write data.
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    operand_nxt = operand_r;
    wdata_nxt = mem_wdata_r;
    done = 1'b0;
    taken = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (load_pc) begin
          pc_nxt = load_addr;
        end else if (run) begin
          state_nxt = ST_REQ;
        end
      end
      ST_REQ: state_nxt = ST_CAP;
      ST_CAP: begin
        pc_nxt = pc_r + 16'h0001;
        state_nxt = ({1'b0, cnt_r} + 3'h1 < {1'b0, len_cur}) ? ST_REQ : ST_ADDR;
      end
      ST_ADDR: begin
        case (cls_cur)
          CLS_JUMP: begin
            pc_nxt = ea_bus.ea;
            done = 1'b1;
          end
          CLS_BRANCH: begin
            if (cond_true) begin
              pc_nxt = ea_bus.target;
              taken = 1'b1;
            end
            done = 1'b1;
          end
          CLS_CTRL: done = 1'b1;
          CLS_RMW: begin
            if (rmw_on_reg) begin
              operand_nxt = (byte_r[0][7:4] == COL_INH_IDX) ? idx : acc;
              state_nxt = ST_EXEC;
            end else begin
              state_nxt = ST_OPREQ;
            end
          end
          CLS_REGMEM: begin
            if (mode_cur == MODE_IMM) begin
              operand_nxt = byte_r[1];
              done = 1'b1;
            end else if (is_store) begin
              wdata_nxt = store_idx ? idx : acc;
              state_nxt = ST_WR;
            end else begin
              state_nxt = ST_OPREQ;
            end
          end
          default: state_nxt = ST_OPREQ;
        endcase
      end
      ST_OPREQ: state_nxt = ST_OPCAP;
      ST_OPCAP: begin
        operand_nxt = mem_rdata;
        state_nxt = ST_EXEC;
      end
      ST_EXEC: begin
        case (cls_cur)
          CLS_RMW: begin
            if (no_writeback || rmw_on_reg) begin
              done = 1'b1;
            end else begin
              wdata_nxt = rmw_res;
              state_nxt = ST_WR;
            end
          end
          CLS_BITMAN: begin
            wdata_nxt = bit_res;
            state_nxt = ST_WR;
          end
          CLS_BITBR: begin
            if (tested_bit == want_high) begin
              pc_nxt = ea_bus.target;
              taken = 1'b1;
            end
            done = 1'b1;
          end
          default: done = 1'b1;
        endcase
      end
      ST_WR: done = 1'b1;
      default: state_nxt = ST_IDLE;
    endcase
    if (done) begin
      state_nxt = ST_IDLE;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Program counter and operand holding register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_r <= RESET_PC;
      operand_r <= RESET_BYTE;
    end else begin
      pc_r <= pc_nxt;
      operand_r <= operand_nxt;
    end
  end

  // Instruction byte capture, slot chosen by the byte counter.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 2'h0;
      for (int i = 0; i < 3; i++) begin
        byte_r[i] <= RESET_BYTE;
      end
    end else if (state_r == ST_IDLE) begin
      cnt_r <= 2'h0;
    end else if (state_r == ST_CAP) begin
      byte_r[cnt_r] <= mem_rdata;
      cnt_r <= cnt_r + 2'h1;
    end
  end

  // Memory requests are registered: fetch at pc, operand access at the effective address.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_rd_r <= 1'b0;
      mem_wr_r <= 1'b0;
      mem_addr_r <= RESET_PC;
      mem_wdata_r <= RESET_BYTE;
    end else begin
      mem_rd_r <= (state_nxt == ST_REQ) || (state_nxt == ST_OPREQ);
      mem_wr_r <= (state_nxt == ST_WR);
      mem_wdata_r <= wdata_nxt;
      if (state_nxt == ST_REQ) begin
        mem_addr_r <= pc_nxt;
      end else if (state_nxt == ST_OPREQ || state_nxt == ST_WR) begin
        mem_addr_r <= ea_bus.ea;
      end
    end
  end

  // One-cycle result pulses and their data.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      instr_done_r <= 1'b0;
      operand_valid_r <= 1'b0;
      branch_taken_r <= 1'b0;
      subr_call_r <= 1'b0;
      carry_wr_r <= 1'b0;
      carry_val_r <= 1'b0;
      flag_wr_r <= 1'b0;
      flag_n_r <= 1'b0;
      flag_z_r <= 1'b0;
      reg_wr_acc_r <= 1'b0;
      reg_wr_idx_r <= 1'b0;
      reg_wdata_r <= RESET_BYTE;
    end else begin
      instr_done_r <= done;
      branch_taken_r <= taken;
      operand_valid_r <= (cls_cur == CLS_REGMEM) && ((state_r == ST_EXEC) ||
        (state_r == ST_ADDR && mode_cur == MODE_IMM));
      subr_call_r <= (state_r == ST_ADDR) && (cls_cur == CLS_JUMP) &&
        (byte_r[0][3:0] == LO_JUMP_SUBROUTINE);
      carry_wr_r <= (state_r == ST_EXEC) && (cls_cur == CLS_BITBR);
      carry_val_r <= tested_bit;
      flag_wr_r <= (state_r == ST_EXEC) && (cls_cur == CLS_RMW);
      flag_n_r <= no_writeback ? operand_r[7] : rmw_res[7];
      flag_z_r <= no_writeback ? (operand_r == 8'h00) : (rmw_res == 8'h00);
      reg_wr_acc_r <= (state_r == ST_EXEC) && (cls_cur == CLS_RMW) && rmw_on_reg && !no_writeback &&
        (byte_r[0][7:4] == COL_INH_ACC);
      reg_wr_idx_r <= (state_r == ST_EXEC) && (cls_cur == CLS_RMW) && rmw_on_reg && !no_writeback &&
        (byte_r[0][7:4] == COL_INH_IDX);
      reg_wdata_r <= rmw_res;
    end
  end

  // Outputs.
  assign busy = (state_r != ST_IDLE);
  assign instr_done = instr_done_r;
  assign mem_rd = mem_rd_r;
  assign mem_wr = mem_wr_r;
  assign mem_addr = mem_addr_r;
  assign mem_wdata = mem_wdata_r;
  assign pc = pc_r;
  assign opcode = byte_r[0];
  assign mode = camd_mode_of(byte_r[0]);
  assign iclass = camd_class_of(byte_r[0]);
  assign instr_len = camd_len_of(camd_mode_of(byte_r[0]));
  assign operand_ea = mem_addr_r;
  assign operand_data = operand_r;
  assign operand_valid = operand_valid_r;
  assign branch_taken = branch_taken_r;
  assign subr_call = subr_call_r;
  assign carry_wr = carry_wr_r;
  assign carry_val = carry_val_r;
  assign flag_wr = flag_wr_r;
  assign flag_n = flag_n_r;
  assign flag_z = flag_z_r;
  assign reg_wr_acc = reg_wr_acc_r;
  assign reg_wr_idx = reg_wr_idx_r;
  assign reg_wdata = reg_wdata_r;

endmodule : camd_decoder

// File: logic/camd_ea_calc.sv
// Effective address and relative branch target formation.
// Assumes the operand bytes and index value are stable while the result is used.
`timescale 1ns/1ns
module camd_ea_calc
  import camd_pkg::*;
(
  // Operand bytes in, addresses out.
  camd_ea_if.calc ea
);

  logic [8:0] short_sum;
  logic [7:0] rel;

  // Eight-bit index sum keeps its carry as address bit eight.
  assign short_sum = {1'b0, ea.idx} + {1'b0, ea.b1};

  // Operand address per mode.
  always_comb begin
    case (ea.mode)
      MODE_DIR, MODE_BTB: ea.ea = {PAGE_ZERO_HI, ea.b1};
      MODE_EXT: ea.ea = {ea.b1, ea.b2};
      MODE_IX0: ea.ea = {PAGE_ZERO_HI, ea.idx};
      MODE_IX1: ea.ea = {7'h00, short_sum};
      MODE_IX2: ea.ea = {ea.b1, ea.b2} + {PAGE_ZERO_HI, ea.idx};
      default: ea.ea = 16'h0000;
    endcase
  end

  // Signed offset from the next instruction's address.
  assign rel = (ea.mode == MODE_BTB) ? ea.b2 : ea.b1;
  assign ea.target = ea.pc_next + {{8{rel[7]}}, rel};

endmodule : camd_ea_calc

// File: logic/camd_ea_if.sv
// Carrier between the sequencer and the address calculator.
// Assumes both ends share one clock; all signals are combinational levels.
`timescale 1ns/1ns
interface camd_ea_if;
  import camd_pkg::*;
  camd_mode_t mode;
  logic [7:0] idx;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [15:0] pc_next;
  logic [15:0] ea;
  logic [15:0] target;

  modport core (output mode, output idx, output b1, output b2, output pc_next, input ea, input target);
  modport calc (input mode, input idx, input b1, input b2, input pc_next, output ea, output target);
endinterface : camd_ea_if

// File: logic/camd_pkg.sv
// Shared constants, types and decode functions for the addressing mode decoder.
// Assumes an 8-bit CPU core with a 16-bit address space and an opcode map split by column.
package camd_pkg;

  // Addressing modes; the bit test-and-branch form combines direct and relative.
  typedef enum logic [3:0] {
    MODE_INH, MODE_IMM, MODE_DIR, MODE_EXT, MODE_IX0, MODE_IX1, MODE_IX2, MODE_REL, MODE_BTB
  } camd_mode_t;

  // Instruction classes.
  typedef enum logic [2:0] {
    CLS_REGMEM, CLS_RMW, CLS_JUMP, CLS_BRANCH, CLS_BITBR, CLS_BITMAN, CLS_CTRL
  } camd_class_t;

  // Opcode column codes (upper nibble).
  localparam logic [3:0] COL_BITBR = 4'h0;
  localparam logic [3:0] COL_BITMAN = 4'h1;
  localparam logic [3:0] COL_REL = 4'h2;
  localparam logic [3:0] COL_DIR_RMW = 4'h3;
  localparam logic [3:0] COL_INH_ACC = 4'h4;
  localparam logic [3:0] COL_INH_IDX = 4'h5;
  localparam logic [3:0] COL_IX1_RMW = 4'h6;
  localparam logic [3:0] COL_IX0_RMW = 4'h7;
  localparam logic [3:0] COL_IMM = 4'hA;
  localparam logic [3:0] COL_DIR = 4'hB;
  localparam logic [3:0] COL_EXT = 4'hC;
  localparam logic [3:0] COL_IX2 = 4'hD;
  localparam logic [3:0] COL_IX1 = 4'hE;
  localparam logic [3:0] COL_IX0 = 4'hF;

  // Opcode row codes (lower nibble).
  localparam logic [3:0] LO_UNCONDITIONAL_JUMP = 4'hC;
  localparam logic [3:0] LO_JUMP_SUBROUTINE = 4'hD;
  localparam logic [3:0] LO_BRANCH_SUBROUTINE = 4'hD;
  localparam logic [3:0] LO_STORE_ACC = 4'h7;
  localparam logic [3:0] LO_STORE_IDX = 4'hF;
  localparam logic [3:0] LO_NEG = 4'h0;
  localparam logic [3:0] LO_COM = 4'h3;
  localparam logic [3:0] LO_LSR = 4'h4;
  localparam logic [3:0] LO_ROR = 4'h6;
  localparam logic [3:0] LO_ASR = 4'h7;
  localparam logic [3:0] LO_LSL = 4'h8;
  localparam logic [3:0] LO_ROL = 4'h9;
  localparam logic [3:0] LO_DEC = 4'hA;
  localparam logic [3:0] LO_INC = 4'hC;
  localparam logic [3:0] LO_TEST_NEGATIVE_ZERO = 4'hD;
  localparam logic [3:0] LO_CLR = 4'hF;

  // Bit field positions inside bit test and bit manipulation opcodes.
  localparam int BIT_SEL_LSB = 1;
  localparam int BIT_SENSE_POS = 0;

  // Instruction lengths in bytes.
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // Fixed high address byte of direct and no-offset indexed access.
  localparam logic [7:0] PAGE_ZERO_HI = 8'h00;

  // Value after reset.
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Mode of an opcode.
  function automatic camd_mode_t camd_mode_of(input logic [7:0] op);
    case (op[7:4])
      COL_BITBR: camd_mode_of = MODE_BTB;
      COL_BITMAN, COL_DIR_RMW, COL_DIR: camd_mode_of = MODE_DIR;
      COL_REL: camd_mode_of = MODE_REL;
      COL_IX1_RMW, COL_IX1: camd_mode_of = MODE_IX1;
      COL_IX0_RMW, COL_IX0: camd_mode_of = MODE_IX0;
      COL_IMM: camd_mode_of = (op[3:0] == LO_BRANCH_SUBROUTINE) ? MODE_REL : MODE_IMM;
      COL_EXT: camd_mode_of = MODE_EXT;
      COL_IX2: camd_mode_of = MODE_IX2;
      default: camd_mode_of = MODE_INH;
    endcase
  endfunction : camd_mode_of

  // Class of an opcode.
  function automatic camd_class_t camd_class_of(input logic [7:0] op);
    case (op[7:4])
      COL_BITBR: camd_class_of = CLS_BITBR;
      COL_BITMAN: camd_class_of = CLS_BITMAN;
      COL_REL: camd_class_of = CLS_BRANCH;
      COL_DIR_RMW, COL_INH_ACC, COL_INH_IDX, COL_IX1_RMW, COL_IX0_RMW: camd_class_of = CLS_RMW;
      COL_IMM: camd_class_of = (op[3:0] == LO_BRANCH_SUBROUTINE) ? CLS_BRANCH : CLS_REGMEM;
      COL_DIR, COL_EXT, COL_IX2, COL_IX1, COL_IX0: begin
        if (op[3:0] == LO_UNCONDITIONAL_JUMP || op[3:0] == LO_JUMP_SUBROUTINE) begin
          camd_class_of = CLS_JUMP;
        end else begin
          camd_class_of = CLS_REGMEM;
        end
      end
      default: camd_class_of = CLS_CTRL;
    endcase
  endfunction : camd_class_of

  // Byte length of a mode.
  function automatic logic [1:0] camd_len_of(input camd_mode_t m);
    case (m)
      MODE_INH, MODE_IX0: camd_len_of = LEN_ONE;
      MODE_EXT, MODE_IX2, MODE_BTB: camd_len_of = LEN_THREE;
      default: camd_len_of = LEN_TWO;
    endcase
  endfunction : camd_len_of

endpackage : camd_pkg

// File: sim/camd_decoder_properties.sv
// Concurrent checks on the decoder's ports.
// Assumes one clock domain and the opcode map of the shared package.
`timescale 1ns/1ns
module camd_decoder_properties
  import camd_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Watched signals.
  input wire logic [7:0] idx,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic instr_done,
  input wire logic [7:0] opcode,
  input wire camd_mode_t mode,
  input wire camd_class_t iclass,
  input wire logic [1:0] instr_len,
  input wire logic [15:0] operand_ea,
  input wire logic operand_valid,
  input wire logic branch_taken,
  input wire logic carry_wr,
  input wire logic reg_wr_acc,
  input wire logic reg_wr_idx
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_dir_page_zero: assert property (operand_valid && mode == MODE_DIR |-> operand_ea[15:8] == 8'h00)
    else $error("direct address off page zero");
  a_ix0_page_zero: assert property (operand_valid && mode == MODE_IX0 |-> operand_ea == {8'h00, idx})
    else $error("no-offset index address wrong");
  a_ix1_reach: assert property (operand_valid && mode == MODE_IX1 |-> operand_ea < 16'h01ff)
    else $error("indexed offset address out of reach");
  a_inh_no_write: assert property (mode inside {MODE_INH, MODE_IMM} |-> !mem_wr)
    else $error("memory write without an address");
  a_tst_no_wb: assert property (iclass == CLS_RMW && opcode[3:0] == 4'hd |-> !(mem_wr || reg_wr_acc || reg_wr_idx))
    else $error("test instruction wrote back");
  a_rmw_wr_done: assert property (mem_wr && iclass == CLS_RMW |=> instr_done ##1 !instr_done)
    else $error("write-back not followed by completion");
  a_carry_at_done: assert property (carry_wr |-> instr_done && iclass == CLS_BITBR && operand_ea[15:8] == 8'h00)
    else $error("carry update outside bit test");
  a_branch_kind: assert property (branch_taken |-> instr_done && iclass inside {CLS_BRANCH, CLS_BITBR})
    else $error("branch taken by a non-branch");
  a_bit_test_len: assert property (carry_wr |-> $past(mem_rd, 3) && instr_len == 2'h3 && mode == MODE_BTB)
    else $error("bit test without its operand read");
endmodule : camd_decoder_properties

bind camd_decoder camd_decoder_properties camd_decoder_properties_inst (.clk, .rstn, .idx, .mem_wr, .instr_done,
  .mem_rd, .opcode, .mode, .iclass, .instr_len, .operand_ea, .operand_valid, .branch_taken, .carry_wr, .reg_wr_acc,
  .reg_wr_idx);

// File: sim/camd_decoder_tb.sv
// Self-checking bench: random instructions run from memory against a bench model.
// Assumes one instruction at a time, started by run from idle.
`timescale 1ns/1ns
module camd_decoder_tb;
  import camd_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic run = 1'b0;
  logic load_pc = 1'b0;
  logic [15:0] load_addr = 16'h0000;
  logic [7:0] acc = 8'h00;
  logic [7:0] idx = 8'h00;
  logic carry_in = 1'b0;
  logic cond_true = 1'b0;
  logic busy, instr_done, mem_rd, mem_wr, operand_valid, branch_taken, subr_call, carry_wr, carry_val;
  logic flag_wr, flag_n, flag_z, reg_wr_acc, reg_wr_idx;
  logic [15:0] mem_addr, pc, operand_ea;
  logic [7:0] mem_rdata, mem_wdata, opcode, operand_data, reg_wdata;
  camd_mode_t mode;
  camd_class_t iclass;
  logic [1:0] instr_len;
  int fail_count = 0;
  int n_compared = 0;
  logic hung = 1'b0;

  // Clock at 100 MHz.
  initial begin
    forever #5 clk = ~clk;
  end

  camd_decoder camd_decoder_inst (.clk, .rstn, .run, .load_pc, .load_addr, .busy, .instr_done, .acc, .idx,
    .carry_in, .cond_true, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .pc, .opcode, .mode, .iclass,
    .instr_len, .operand_ea, .operand_data, .operand_valid, .branch_taken, .subr_call, .carry_wr, .carry_val,
    .flag_wr, .flag_n, .flag_z, .reg_wr_acc, .reg_wr_idx, .reg_wdata);
  camd_mem camd_mem_inst (.clk, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata);

  // Verdict and end of run.
  task automatic report_and_stop();
    if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // Compares one result with the model.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Result of a read-modify-write row.
  function automatic logic [7:0] alu(input logic [3:0] r, input logic [7:0] v, input logic ci);
    case (r)
      4'h0: alu = 8'h00 - v;
      4'h3: alu = ~v;
      4'h4: alu = v >> 1;
      4'h6: alu = {ci, v[7:1]};
      4'h7: alu = {v[7], v[7:1]};
      4'h8: alu = v << 1;
      4'h9: alu = {v[6:0], ci};
      4'ha: alu = v - 8'h01;
      4'hc: alu = v + 8'h01;
      4'hf: alu = 8'h00;
      default: alu = v;
    endcase
  endfunction : alu

  // Opcodes the bench models.
  function automatic bit op_ok(input logic [3:0] c, input logic [3:0] r);
    if (c inside {[4'h3:4'h7]}) return r inside {4'h0, 4'h3, 4'h4, [4'h6:4'ha], 4'hc, 4'hd, 4'hf};
    if (c >= 4'ha) return !(c == 4'ha && (r == 4'h7 || r == 4'hf));
    return 1'b1;
  endfunction : op_ok

  // Runs one instruction from a random place and checks every result except mode and iclass.
  task automatic run1(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] x,
                      input logic ct);
    logic [3:0] c, r;
    logic [15:0] base, ea, pe, wa;
    logic [7:0] a, d, res, wd, wx, rw, od;
    logic [1:0] len, fl, rs;
    logic ci, tk, bt, cv, memop, st, we, jp, bsr, sc;
    int nrd, nwr;
    c = op[7:4];
    r = op[3:0];
    base = 16'($urandom);
    a = 8'($urandom);
    ci = 1'($urandom);
    jp = c > 4'ha && (r == 4'hc || r == 4'hd);
    bsr = c == 4'ha && r == 4'hd;
    len = (c == 4'h0 || c == 4'hc || c == 4'hd) ? 2'h3 : (c inside {4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'hf}) ? 2'h1 : 2'h2;
    case (c)
      4'h0, 4'h1, 4'h3, 4'hb: ea = {8'h00, b1};
      4'hc: ea = {b1, b2};
      4'hd: ea = {b1, b2} + x;
      4'h6, 4'he: ea = b1 + x;
      default: ea = {8'h00, x};
    endcase
    camd_mem_inst.m[ea] = 8'($urandom);
    camd_mem_inst.m[base] = op;
    camd_mem_inst.m[base + 16'h0001] = b1;
    camd_mem_inst.m[base + 16'h0002] = b2;
    d = camd_mem_inst.m[ea];
    memop = (c inside {4'h0, 4'h1, 4'h3, 4'h6, 4'h7} || c > 4'ha) && !jp;
    st = c > 4'ha && (r == 4'h7 || r == 4'hf);
    res = alu(r, c == 4'h4 ? a : c == 4'h5 ? x : d, ci);
    we = c == 4'h1 || st || (c inside {4'h3, 4'h6, 4'h7} && r != 4'hd);
    wx = st ? (r == 4'h7 ? a : x) : res;
    if (c == 4'h1) wx = r[0] ? d & ~(8'h01 << r[3:1]) : d | (8'h01 << r[3:1]);
    tk = c == 4'h0 ? d[r[3:1]] == ~r[0] : (c == 4'h2 || bsr) && ct;
    pe = jp ? ea : base + len;
    if (tk) pe = pe + (c == 4'h0 ? {{8{b2[7]}}, b2} : {{8{b1[7]}}, b1});
    @(posedge clk);
    load_pc <= 1'b1;
    load_addr <= base;
    acc <= a;
    idx <= x;
    carry_in <= ci;
    cond_true <= ct;
    @(posedge clk);
    load_pc <= 1'b0;
    run <= 1'b1;
    @(posedge clk);
    run <= 1'b0;
    nrd = 0;
    nwr = 0;
    rs = 2'h0;
    bt = 1'b0;
    sc = 1'b0;
    for (int n = 0; n < 40; n++) begin
      #1;
      if (n == 0) chk(busy, 1'b1);
      if (subr_call === 1'b1) sc = 1'b1;
      if (mem_rd === 1'b1) nrd++;
      if (mem_wr === 1'b1) begin
        nwr++;
        wa = mem_addr;
        wd = mem_wdata;
      end
      if (reg_wr_acc === 1'b1 || reg_wr_idx === 1'b1) begin
        rs = {reg_wr_acc, reg_wr_idx};
        rw = reg_wdata;
      end
      if (branch_taken === 1'b1) bt = 1'b1;
      if (carry_wr === 1'b1) cv = carry_val;
      if (flag_wr === 1'b1) fl = {flag_n, flag_z};
      if (operand_valid === 1'b1) od = operand_data;
      if (instr_done === 1'b1) break;
      @(posedge clk);
    end
    if (instr_done !== 1'b1) begin
      fail_count++;
      hung = 1'b1;
      return;
    end
    chk(pc, pe);
    chk(opcode, op);
    chk(sc, jp && r == 4'hd);
    chk(instr_len, len);
    chk(16'(nrd), len + (memop && !st));
    chk(bt, tk);
    if (memop) chk(operand_ea, ea);
    chk(16'(nwr), we);
    if (we) chk(wa, ea);
    if (we) chk(wd, wx);
    if (c == 4'h0) chk(cv, d[r[3:1]]);
    if (c inside {[4'h3:4'h7]}) chk(fl, {res[7], res == 8'h00});
    if (c inside {4'h4, 4'h5}) chk(rs, r == 4'hd ? 2'h0 : c == 4'h4 ? 2'h2 : 2'h1);
    if (rs != 2'h0) chk(rw, res);
    if (c >= 4'ha && !st && !jp && !bsr) chk(od, c == 4'ha ? b1 : d);
  endtask : run1

  // Reset, edge cases of the address sums and branches, then random opcodes.
  initial begin
    logic [7:0] op;
    void'($urandom(32'hf839_e04a));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    run1(8'he6, 8'hff, 8'h00, 8'hff, 1'b0);
    run1(8'hd6, 8'hff, 8'hf0, 8'h20, 1'b0);
    run1(8'h20, 8'h80, 8'h00, 8'h11, 1'b1);
    run1(8'h21, 8'h7f, 8'h00, 8'h11, 1'b1);
    run1(8'h22, 8'h7f, 8'h00, 8'h11, 1'b0);
    repeat (300) begin
      if (hung) break;
      do op = 8'($urandom); while (!op_ok(op[7:4], op[3:0]));
      run1(op, 8'($urandom), 8'($urandom), 8'($urandom), 1'($urandom));
    end
    report_and_stop();
  end
endmodule : camd_decoder_tb

// File: sim/camd_mem.sv
// Byte memory standing on the far side of the decoder.
// Assumes one-cycle read latency and a write taken at the strobe edge.
`timescale 1ns/1ns
module camd_mem (
  // Clock.
  input wire logic clk,
  // Requests.
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  // Answer.
  output logic [7:0] mem_rdata
);
  logic [7:0] m [0:65535];

  // Read data stands one cycle, then the line toggles so stale data never looks valid.
  initial mem_rdata = 8'h5a;
  always @(posedge clk) begin
    if (mem_wr) m[mem_addr] <= mem_wdata;
    if (mem_rd) mem_rdata <= m[mem_addr];
    else mem_rdata <= ~mem_rdata;
  end
endmodule : camd_mem
